// ===== core/utm_cnt_if.sv
// count strobes and byte access between the port logic and one timer
`timescale 1ns/100ps
interface utm_cnt_if;
  logic [1:0] mode;
  logic       inc_lo;
  logic       inc_hi;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic       ovf_lo;
  logic       ovf_hi;
  modport ctl (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata, input lo, hi, ovf_lo, ovf_hi);
  modport tmr (input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata, output lo, hi, ovf_lo, ovf_hi);
endinterface

// ===== core/utm_core.sv
// serial port with two timer/counters, timer 1 overflow as baud source
// Functional notes
// [R1] 13-bit mode wraps and sets overflow flag
// [R2] count only when run and gate allow
// [R3] 13-bit count uses high byte, low five
// [R4] run bit never clears the count
// [R5] gate bits at mode bits seven, three
// [R6] 16-bit mode uses both bytes fully
// [R7] 8-bit mode reloads low from high
// [R8] timer one mode three stops it
// [R9] timer zero split: two byte counters
// [R10] timer one still clocks baud then
// [R11] toggle pin on overflow, starts high
// [R12] full duplex, second byte overwrites unread
// [R13] write loads transmit, read gives receive
// [R14] shift mode: eight bits, clock sixth
// [R15] ten-bit frame, stop into ninth field
// [R16] eleven-bit frame with programmable ninth bit
// [R17] fixed mode rate thirty-second or sixteenth
// [R18] variable rate from timer one overflow
// [R19] receive start conditions per mode
// [R20] buffer write always starts transmission; the code ignores a write unless the transmitter is in TX_IDLE
// [R21] bit seven shows error or mode
// [R22] timer ticks every six clocks
// [R23] counter counts sampled falling pin edges
// [R24] sixteen-times sampling, divider reset on start
// [R25] done flags set by hardware, software clears
`timescale 1ns/100ps
module utm_core
  import utm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] timer_mode_register,
  input  wire logic       timer0_run_bit,
  input  wire logic       timer1_run_bit,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag,
  input  wire logic [1:0] timer_flag_clr,
  input  wire logic [1:0] ext_gate_input,
  input  wire logic [3:0] count_byte_wr,
  input  wire logic [7:0] count_byte_wdata,
  output logic [7:0]      timer0_low_byte,
  output logic [7:0]      timer0_high_byte,
  output logic [7:0]      timer1_low_byte,
  output logic [7:0]      timer1_high_byte,
  input  wire logic       toggle_enable_zero,
  input  wire logic       toggle_enable_one,
  input  wire logic       count_pin_zero_in,
  output logic            count_pin_zero_out,
  output logic            count_pin_zero_oe,
  input  wire logic       count_pin_one_in,
  output logic            count_pin_one_out,
  output logic            count_pin_one_oe,
  input  wire logic       serial_buffer_wr,
  input  wire logic [7:0] serial_buffer_wdata,
  output logic [7:0]      serial_buffer_rdata,
  input  wire logic       serial_mode_bit_zero,
  input  wire logic       serial_mode_bit_one,
  input  wire logic       receive_enable,
  input  wire logic       transmit_ninth_bit,
  output logic            received_ninth_bit,
  output logic            tx_done_flag,
  output logic            rx_done_flag,
  output logic            framing_error_flag,
  input  wire logic       tx_done_clr,
  input  wire logic       rx_done_clr,
  input  wire logic       framing_error_clr,
  input  wire logic       error_view_select,
  input  wire logic       baud_doubling_bit,
  output logic            serial_ctrl_bit7,
  input  wire logic       ser_data_in,
  output logic            ser_data_out,
  output logic            ser_data_oe,
  output logic            ser_clk_tx_out
);
  utm_cnt_if t0 ();
  utm_cnt_if t1 ();

  utm_timer u_timer0 (.core_clk(core_clk), .rst_b(rst_b), .cnt(t0.tmr));
  utm_timer u_timer1 (.core_clk(core_clk), .rst_b(rst_b), .cnt(t1.tmr));

  // pin synchronisers
  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  wire  [4:0] pins_raw = {ser_data_in, ext_gate_input, count_pin_one_in, count_pin_zero_in};

  // machine cycle phase
  logic [2:0] ph_q;
  wire  [2:0] ph_d    = (ph_q == MC_LAST) ? 3'h0 : ph_q + 3'h1;
  wire        mc_tick = (ph_q == MC_LAST); // R22
  wire        sclk    = !((ph_q >= SCLK_LO_FIRST) && (ph_q <= SCLK_LO_LAST));

  // timer control decode
  logic [1:0] samp_q;
  wire [1:0] t0_mode = timer_mode_register[T0_MODE_LSB +: 2];
  wire [1:0] t1_mode = timer_mode_register[T1_MODE_LSB +: 2];
  wire       t0_split = (t0_mode == TM_SPLIT);
  wire [1:0] fall = {2{mc_tick}} & samp_q & ~sy2_q[PIN_CNT1:PIN_CNT0]; // R23
  wire gate0_ok = !timer_mode_register[T0_GATE_BIT] || sy2_q[PIN_GATE0]; // R5
  wire gate1_ok = !timer_mode_register[T1_GATE_BIT] || sy2_q[PIN_GATE1]; // R5
  wire en0 = timer0_run_bit && gate0_ok; // R2
  wire t1_run = t0_split ? 1'b1 : timer1_run_bit; // R10
  wire en1 = t1_run && gate1_ok && (t1_mode != TM_SPLIT); // R8
  wire src0 = timer_mode_register[T0_CT_BIT] ? fall[0] : mc_tick;
  wire src1 = timer_mode_register[T1_CT_BIT] ? fall[1] : mc_tick;

  assign t0.mode   = t0_mode;
  assign t0.inc_lo = en0 && src0;
  assign t0.inc_hi = t0_split && timer1_run_bit && mc_tick; // R9
  assign t0.wr_lo  = count_byte_wr[0];
  assign t0.wr_hi  = count_byte_wr[1];
  assign t0.wdata  = count_byte_wdata;
  assign t1.mode   = t1_mode;
  assign t1.inc_lo = en1 && src1;
  assign t1.inc_hi = 1'b0;
  assign t1.wr_lo  = count_byte_wr[2];
  assign t1.wr_hi  = count_byte_wr[3];
  assign t1.wdata  = count_byte_wdata;

  assign timer0_low_byte  = t0.lo;
  assign timer0_high_byte = t0.hi;
  assign timer1_low_byte  = t1.lo;
  assign timer1_high_byte = t1.hi;

  // overflow flags: a set in the clear cycle wins
  logic tf0_q;
  logic tf1_q;
  wire  tf1_set = t0_split ? t0.ovf_hi : t1.ovf_lo; // R10
  wire  tf0_d   = t0.ovf_lo || (tf0_q && !timer_flag_clr[0]); // R1
  wire  tf1_d   = tf1_set || (tf1_q && !timer_flag_clr[1]);
  assign timer0_overflow_flag = tf0_q;
  assign timer1_overflow_flag = tf1_q;

  // overflow toggle outputs, held high while disabled
  logic tog0_q;
  logic tog1_q;
  wire  tog0_d = !toggle_enable_zero || (tog0_q ^ t0.ovf_lo); // R11
  wire  tog1_d = !toggle_enable_one || (tog1_q ^ t1.ovf_lo); // R11
  assign count_pin_zero_out = tog0_q;
  assign count_pin_zero_oe  = toggle_enable_zero;
  assign count_pin_one_out  = tog1_q;
  assign count_pin_one_oe   = toggle_enable_one;

  // baud generation
  logic       half_q;
  logic [3:0] tdiv_q;
  wire [1:0] smode = {serial_mode_bit_zero, serial_mode_bit_one};
  wire       m0    = (smode == SM_SHIFT);
  wire       nine  = (smode == SM_FIXED11) || (smode == SM_TIMED11);
  wire       base  = (smode == SM_FIXED11) ? 1'b1 : t1.ovf_lo; // R17 R18
  wire       tick16 = base && (baud_doubling_bit || half_q); // R17 R18
  wire [3:0] frame_bits = m0 ? BITS_SHIFT : (nine ? BITS_ASYNC11 : BITS_ASYNC10);
  wire       tx_tick = m0 ? mc_tick : (tick16 && (tdiv_q == OS_LAST)); // R14

  // transmitter
  utm_tx_type  tx_st_q;
  utm_tx_type  tx_st_d;
  logic [10:0] tx_sh_q;
  logic [10:0] tx_sh_d;
  logic [3:0]  tx_cnt_q;
  logic [3:0]  tx_cnt_d;
  logic        ti_set;
  logic        ti_q;
  wire [10:0] tx_load = m0 ? {3'h7, serial_buffer_wdata}
                           : {1'b1, nine ? transmit_ninth_bit : 1'b1, serial_buffer_wdata, 1'b0}; // R15 R16

  always_comb
  begin
    tx_st_d  = tx_st_q;
    tx_sh_d  = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    ti_set   = 1'b0;
    case (tx_st_q)
      TX_IDLE:
      begin
        if (serial_buffer_wr)
        begin
          tx_st_d  = TX_WAIT; // R20 R13
          tx_sh_d  = tx_load;
          tx_cnt_d = frame_bits;
        end
      end
      TX_WAIT:
      begin
        if (tx_tick)
          tx_st_d = TX_SEND;
      end
      TX_SEND:
      begin
        if (tx_tick)
        begin
          if (tx_cnt_q == 4'h1)
          begin
            tx_st_d = TX_IDLE;
            ti_set  = 1'b1; // R25
          end
          else
          begin
            tx_sh_d  = {1'b1, tx_sh_q[10:1]};
            tx_cnt_d = tx_cnt_q - 4'h1;
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  // receiver
  utm_rx_type rx_st_q;
  utm_rx_type rx_st_d;
  logic [9:0] rx_sh_q;
  logic [9:0] rx_sh_d;
  logic [3:0] rcnt_q;
  logic [3:0] rcnt_d;
  logic [3:0] rdiv_q;
  logic [3:0] rdiv_d;
  logic       rx_prev_q;
  logic [7:0] rbuf_q;
  logic [7:0] rbuf_d;
  logic       rb8_q;
  logic       rb8_d;
  logic       ri_set;
  logic       fe_set;
  logic       ri_q;
  logic       fe_q;
  wire        rxd_s   = sy2_q[PIN_SER];
  wire [3:0]  rx_last = frame_bits - 4'h1;
  wire        rx_mid  = tick16 && (rdiv_q == OS_MID); // R24

  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rcnt_d  = rcnt_q;
    rdiv_d  = tick16 ? rdiv_q + 4'h1 : rdiv_q;
    rbuf_d  = rbuf_q;
    rb8_d   = rb8_q;
    ri_set  = 1'b0;
    fe_set  = 1'b0;
    case (rx_st_q)
      RX_IDLE:
      begin
        rcnt_d = 4'h0;
        if (m0 && receive_enable && !ri_q)
          rx_st_d = RX_SHIFT; // R19
        else if (!m0 && receive_enable && tick16 && rx_prev_q && !rxd_s)
        begin
          rx_st_d = RX_FRAME; // R19
          rdiv_d  = 4'h0; // R24
        end
      end
      RX_SHIFT:
      begin
        if (mc_tick)
        begin
          rx_sh_d = {rxd_s, rx_sh_q[9:1]}; // R14
          rcnt_d  = rcnt_q + 4'h1;
          if (rcnt_q == rx_last)
          begin
            rx_st_d = RX_IDLE;
            rbuf_d  = {rxd_s, rx_sh_q[9:3]};
            ri_set  = 1'b1;
          end
        end
      end
      RX_FRAME:
      begin
        if (rx_mid)
        begin
          rcnt_d = rcnt_q + 4'h1;
          if ((rcnt_q == 4'h0) && rxd_s)
            rx_st_d = RX_IDLE;
          else if (rcnt_q == rx_last)
          begin
            rx_st_d = RX_IDLE;
            rbuf_d  = nine ? rx_sh_q[8:1] : rx_sh_q[9:2]; // R12
            rb8_d   = nine ? rx_sh_q[9] : rxd_s; // R15 R16
            fe_set  = !rxd_s; // R21
            ri_set  = 1'b1; // R25
          end
          else if (rcnt_q != 4'h0)
            rx_sh_d = {rxd_s, rx_sh_q[9:1]};
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  // serial flags: a set in the clear cycle wins
  wire ti_d = ti_set || (ti_q && !tx_done_clr); // R25
  wire ri_d = ri_set || (ri_q && !rx_done_clr); // R25
  wire fe_d = fe_set || (fe_q && !framing_error_clr); // R21
  wire clk_on = (tx_st_q == TX_SEND) || (rx_st_q == RX_SHIFT);
  wire txd_d  = m0 ? (!clk_on || sclk) : ((tx_st_q != TX_SEND) || tx_sh_q[0]);
  logic txd_q;

  assign serial_buffer_rdata = rbuf_q; // R13
  assign received_ninth_bit  = rb8_q;
  assign tx_done_flag        = ti_q;
  assign rx_done_flag        = ri_q;
  assign framing_error_flag  = fe_q;
  assign serial_ctrl_bit7    = error_view_select ? fe_q : serial_mode_bit_zero; // R21
  assign ser_data_out        = tx_sh_q[0];
  assign ser_data_oe         = m0 && (tx_st_q == TX_SEND); // R14
  assign ser_clk_tx_out      = txd_q;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sy1_q  <= 5'h1f;
      sy2_q  <= 5'h1f;
      ph_q   <= 3'h0;
      samp_q <= 2'h3;
      tf0_q  <= 1'b0;
      tf1_q  <= 1'b0;
      tog0_q <= 1'b1;
      tog1_q <= 1'b1;
      half_q <= 1'b0;
      tdiv_q <= 4'h0;
    end
    else
    begin
      sy1_q  <= pins_raw;
      sy2_q  <= sy1_q;
      ph_q   <= ph_d;
      samp_q <= mc_tick ? sy2_q[PIN_CNT1:PIN_CNT0] : samp_q;
      tf0_q  <= tf0_d;
      tf1_q  <= tf1_d;
      tog0_q <= tog0_d;
      tog1_q <= tog1_d;
      half_q <= half_q ^ base;
      tdiv_q <= tick16 ? tdiv_q + 4'h1 : tdiv_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 11'h7ff;
      tx_cnt_q  <= 4'h0;
      ti_q      <= 1'b0;
      txd_q     <= 1'b1;
      rx_st_q   <= RX_IDLE;
      rx_sh_q   <= 10'h000;
      rcnt_q    <= 4'h0;
      rdiv_q    <= 4'h0;
      rx_prev_q <= 1'b1;
      rbuf_q    <= 8'h00;
      rb8_q     <= 1'b0;
      ri_q      <= 1'b0;
      fe_q      <= 1'b0;
    end
    else
    begin
      tx_st_q   <= tx_st_d;
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      ti_q      <= ti_d;
      txd_q     <= txd_d;
      rx_st_q   <= rx_st_d;
      rx_sh_q   <= rx_sh_d;
      rcnt_q    <= rcnt_d;
      rdiv_q    <= rdiv_d;
      rx_prev_q <= tick16 ? rxd_s : rx_prev_q;
      rbuf_q    <= rbuf_d;
      rb8_q     <= rb8_d;
      ri_q      <= ri_d;
      fe_q      <= fe_d;
    end
  end

  chk_mc_six_clocks: assert property (@(posedge core_clk) disable iff (!rst_b) // R22
    mc_tick |=> !mc_tick [*5] ##1 mc_tick)
    else $error("machine cycle is not six clocks");
  chk_gate_blocks_count: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
    (!timer0_run_bit || (timer_mode_register[T0_GATE_BIT] && !sy2_q[PIN_GATE0])) |-> !t0.inc_lo)
    else $error("timer 0 counted while held");
  chk_mode3_stops_t1: assert property (@(posedge core_clk) disable iff (!rst_b) // R8
    (t1_mode == TM_SPLIT) && !count_byte_wr[2] && !count_byte_wr[3] |=> $stable(t1.lo) && $stable(t1.hi))
    else $error("timer 1 moved in mode 3");
  chk_overflow_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
    t0.ovf_lo |=> timer0_overflow_flag)
    else $error("timer 0 overflow flag not set");
  chk_toggle_on_ovf: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
    toggle_enable_zero && t0.ovf_lo |=> !toggle_enable_zero || (count_pin_zero_out != $past(count_pin_zero_out)))
    else $error("toggle pin did not invert");
  chk_tx_done_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // R25
    tx_done_flag && !tx_done_clr |=> tx_done_flag)
    else $error("tx done flag lost without clear");
  chk_fe_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // R21
    framing_error_flag && !framing_error_clr |=> framing_error_flag)
    else $error("framing error flag lost without clear");
  chk_write_starts_tx: assert property (@(posedge core_clk) disable iff (!rst_b) // R20
    serial_buffer_wr && (tx_st_q == TX_IDLE) |=> (tx_st_q == TX_WAIT) && (tx_sh_q[8:1] == $past(serial_buffer_wdata)
      || m0))
    else $error("buffer write did not start transmission");
  chk_split_high_tick: assert property (@(posedge core_clk) disable iff (!rst_b) // R9
    t0_split && timer1_run_bit && !mc_tick |-> !t0.inc_hi ##1 1'b1)
    else $error("split high byte counted off machine cycle");
endmodule

// ===== core/utm_pkg.sv
// shared constants and state types for the timer-clocked serial port
package utm_pkg;
  localparam int         MC_CLKS       = 6;
  localparam logic [2:0] MC_LAST       = 3'(MC_CLKS - 1);
  localparam logic [2:0] SCLK_LO_FIRST = 3'h2;
  localparam logic [2:0] SCLK_LO_LAST  = 3'h4;
  localparam logic [1:0] TM_13BIT      = 2'h0;
  localparam logic [1:0] TM_16BIT      = 2'h1;
  localparam logic [1:0] TM_RELOAD     = 2'h2;
  localparam logic [1:0] TM_SPLIT      = 2'h3;
  localparam logic [1:0] SM_SHIFT      = 2'h0;
  localparam logic [1:0] SM_ASYNC10    = 2'h1;
  localparam logic [1:0] SM_FIXED11    = 2'h2;
  localparam logic [1:0] SM_TIMED11    = 2'h3;
  localparam int         T0_MODE_LSB   = 0;
  localparam int         T0_CT_BIT     = 2;
  localparam int         T0_GATE_BIT   = 3;
  localparam int         T1_MODE_LSB   = 4;
  localparam int         T1_CT_BIT     = 6;
  localparam int         T1_GATE_BIT   = 7;
  localparam logic [4:0] LO13_FULL     = 5'h1f;
  localparam logic [7:0] BYTE_FULL     = 8'hff;
  localparam logic [3:0] OS_LAST       = 4'hf;
  localparam logic [3:0] OS_MID        = 4'h7;
  localparam logic [3:0] BITS_SHIFT    = 4'h8;
  localparam logic [3:0] BITS_ASYNC10  = 4'ha;
  localparam logic [3:0] BITS_ASYNC11  = 4'hb;
  localparam int         PIN_CNT0      = 0;
  localparam int         PIN_CNT1      = 1;
  localparam int         PIN_GATE0     = 2;
  localparam int         PIN_GATE1     = 3;
  localparam int         PIN_SER       = 4;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} utm_tx_type;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_SHIFT = 3'b010, RX_FRAME = 3'b100} utm_rx_type;
endpackage

// ===== core/utm_timer.sv
// one timer/counter: 13-bit, 16-bit, 8-bit reload and split byte modes
`timescale 1ns/100ps
module utm_timer
  import utm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  utm_cnt_if.tmr   cnt
);
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;

  wire       pair     = (cnt.mode == TM_13BIT) || (cnt.mode == TM_16BIT);
  wire       lo_full  = (cnt.mode == TM_13BIT) ? (lo_q[4:0] == LO13_FULL) : (lo_q == BYTE_FULL);
  wire       hi_full  = (hi_q == BYTE_FULL);
  wire [7:0] lo_inc   = lo_q + 8'h01;
  wire [4:0] lo13_inc = lo_q[4:0] + 5'h01;
  wire [7:0] hi_inc   = hi_q + 8'h01;

  assign cnt.ovf_lo = cnt.inc_lo && lo_full && (!pair || hi_full); // R1
  assign cnt.ovf_hi = cnt.inc_hi && hi_full && (cnt.mode == TM_SPLIT);
  assign cnt.lo     = lo_q;
  assign cnt.hi     = hi_q;

  always_comb
  begin
    lo_d = lo_q; // R4
    hi_d = hi_q;
    if (cnt.inc_lo)
    begin
      case (cnt.mode)
        TM_13BIT:
        begin
          lo_d = {lo_q[7:5], lo13_inc}; // R3
          if (lo_full)
            hi_d = hi_inc;
        end
        TM_RELOAD: lo_d = lo_full ? hi_q : lo_inc; // R7
        default:
        begin
          lo_d = lo_inc; // R6
          if (lo_full && pair)
            hi_d = hi_inc;
        end
      endcase
    end
    if (cnt.inc_hi && (cnt.mode == TM_SPLIT))
      hi_d = hi_inc; // R9
    if (cnt.wr_lo)
      lo_d = cnt.wdata;
    if (cnt.wr_hi)
      hi_d = cnt.wdata;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lo_q <= 8'h00;
      hi_q <= 8'h00;
    end
    else
    begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

  chk_reload_from_high: assert property (@(posedge core_clk) disable iff (!rst_b) // R7
    (cnt.mode == TM_RELOAD) && cnt.ovf_lo && !cnt.wr_lo && !cnt.wr_hi |=> (lo_q == $past(hi_q)) && $stable(hi_q))
    else $error("reload did not copy high byte");
  chk_wrap_thirteen: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
    (cnt.mode == TM_13BIT) && cnt.ovf_lo && !cnt.wr_lo && !cnt.wr_hi |=> (lo_q[4:0] == 5'h00) && (hi_q == 8'h00))
    else $error("13-bit count did not wrap to zero");
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the timer-clocked serial port
`timescale 1ns/100ps
module tb_top;
  logic [7:0]  timer_mode_register, count_byte_wdata, serial_buffer_wdata, sd, a, b;
  logic [7:0]  timer0_low_byte, timer0_high_byte, timer1_low_byte, timer1_high_byte, serial_buffer_rdata;
  logic [3:0]  count_byte_wr;
  logic [1:0]  timer_flag_clr, ext_gate_input;
  logic [10:0] fr;
  logic        core_clk, rst_b, timer0_run_bit, timer1_run_bit, toggle_enable_zero, toggle_enable_one;
  logic        cp0_drv, count_pin_one_in, rem_rxd, serial_buffer_wr, serial_mode_bit_zero, serial_mode_bit_one;
  logic        receive_enable, transmit_ninth_bit, tx_done_clr, rx_done_clr, framing_error_clr;
  logic        error_view_select, baud_doubling_bit, timer0_overflow_flag, timer1_overflow_flag;
  logic        count_pin_zero_out, count_pin_zero_oe, count_pin_one_out, count_pin_one_oe;
  logic        received_ninth_bit, tx_done_flag, rx_done_flag, framing_error_flag, serial_ctrl_bit7;
  logic        ser_data_out, ser_data_oe, ser_clk_tx_out;
  wire logic   count_pin_zero_in = count_pin_zero_oe ? count_pin_zero_out : cp0_drv;
  wire logic   ser_data_in = ser_data_oe ? ser_data_out : rem_rxd;
  int          n_fail = 0, check_count = 0, cyc = 0, per;

  utm_core u_dut
  (
    .core_clk, .rst_b, .timer_mode_register, .timer0_run_bit, .timer1_run_bit, .timer0_overflow_flag,
    .timer1_overflow_flag, .timer_flag_clr, .ext_gate_input, .count_byte_wr, .count_byte_wdata,
    .timer0_low_byte, .timer0_high_byte, .timer1_low_byte, .timer1_high_byte, .toggle_enable_zero,
    .toggle_enable_one, .count_pin_zero_in, .count_pin_zero_out, .count_pin_zero_oe, .count_pin_one_in,
    .count_pin_one_out, .count_pin_one_oe, .serial_buffer_wr, .serial_buffer_wdata, .serial_buffer_rdata,
    .serial_mode_bit_zero, .serial_mode_bit_one, .receive_enable, .transmit_ninth_bit, .received_ninth_bit,
    .tx_done_flag, .rx_done_flag, .framing_error_flag, .tx_done_clr, .rx_done_clr, .framing_error_clr,
    .error_view_select, .baud_doubling_bit, .serial_ctrl_bit7, .ser_data_in, .ser_data_out, .ser_data_oe,
    .ser_clk_tx_out
  );

  utm_remote u_rem
  (
    .core_clk (core_clk),
    .tx_line  (ser_clk_tx_out),
    .sdo      (ser_data_out),
    .rxd      (rem_rxd)
  );

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    clk(1);
    s = 1'b0;
  endtask

  task automatic wr_cnt(input int idx, input logic [7:0] v);
    count_byte_wr = 4'(1 << idx);
    count_byte_wdata = v;
    clk(1);
    count_byte_wr = 4'h0;
    clk(1);
  endtask

  task automatic wr_serial_buffer(input logic [7:0] v);
    serial_buffer_wdata = v;
    serial_buffer_wr = 1'b1;
    clk(1);
    serial_buffer_wr = 1'b0;
  endtask

  // timer 0 from a preset value until its overflow flag rises
  task automatic ovf(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi);
    timer0_run_bit = 1'b0;
    timer_mode_register = md;
    wr_cnt(0, lo);
    wr_cnt(1, hi);
    timer_flag_clr = 2'h1;
    clk(1);
    timer_flag_clr = 2'h0;
    timer0_run_bit = 1'b1;
    wait (timer0_overflow_flag === 1'b1);
    clk(1);
    timer0_run_bit = 1'b0;
  endtask

  task automatic moved(input logic exp, input string nm);
    b = timer0_low_byte;
    clk(30);
    chk(16'(timer0_low_byte != b), 16'(exp), nm);
  endtask

  task automatic tx_chk(input logic [7:0] v, input int nb, input int bt, input logic [10:0] exp);
    wr_serial_buffer(v);
    chk(16'(tx_done_flag), 16'h0, "tx done early");
    u_rem.get(fr, nb, bt);
    chk(16'(fr), 16'(exp), "tx frame");
    wait (tx_done_flag === 1'b1);
    clk(1);
    pulse(tx_done_clr);
    chk(16'(tx_done_flag), 16'h0, "tx done clear");
  endtask

  initial
  begin
    {core_clk, rst_b, timer0_run_bit, timer1_run_bit, toggle_enable_zero, toggle_enable_one, serial_buffer_wr,
     serial_mode_bit_zero, serial_mode_bit_one, receive_enable, transmit_ninth_bit, tx_done_clr, rx_done_clr,
     framing_error_clr, error_view_select, baud_doubling_bit} = '0;
    {cp0_drv, count_pin_one_in} = 2'h3;
    {timer_mode_register, count_byte_wdata, serial_buffer_wdata} = '0;
    {count_byte_wr, timer_flag_clr, ext_gate_input} = '0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    clk(1);
    timer_mode_register = 8'h01;
    timer0_run_bit = 1'b1;
    clk(7);
    a = timer0_low_byte;
    timer0_run_bit = 1'b0;
    clk(30);
    chk(16'(timer0_low_byte), 16'(a), "stopped count");
    timer0_run_bit = 1'b1;
    clk(60);
    chk(16'(timer0_low_byte), 16'(a + 8'ha), "count rate");
    timer_mode_register = 8'h81;
    moved(1'b1, "other gate");
    timer_mode_register = 8'h09;
    moved(1'b0, "gate low");
    ext_gate_input = 2'h1;
    moved(1'b1, "gate high");
    toggle_enable_zero = 1'b1;
    chk({count_pin_one_out, count_pin_zero_out}, 16'h3, "toggle idle");
    ovf(8'h01, 8'hff, 8'hff);
    chk({timer0_high_byte, timer0_low_byte}, 16'h0, "wrap 16");
    chk({count_pin_one_oe, count_pin_zero_oe, count_pin_one_out, count_pin_zero_out}, 16'h6, "toggle flip");
    toggle_enable_zero = 1'b0;
    ovf(8'h00, 8'h3f, 8'hff);
    chk(16'({timer0_high_byte, timer0_low_byte[4:0]}), 16'h0, "wrap 13");
    ovf(8'h02, 8'hfe, 8'ha5);
    chk({timer0_high_byte, timer0_low_byte}, 16'ha5a5, "reload");
    timer_mode_register = 8'h05;
    wr_cnt(0, 8'h00);
    timer0_run_bit = 1'b1;
    repeat (3)
    begin
      cp0_drv = 1'b0;
      clk(12);
      cp0_drv = 1'b1;
      clk(12);
    end
    clk(12);
    chk(16'(timer0_low_byte), 16'h3, "event count");
    timer0_run_bit = 1'b0;
    timer_mode_register = 8'h30;
    timer1_run_bit = 1'b1;
    a = timer1_low_byte;
    clk(30);
    chk(16'(timer1_low_byte), 16'(a), "t1 mode3 stop");
    timer_mode_register = 8'h23;
    a = timer0_low_byte;
    b = timer1_low_byte;
    wr_cnt(1, 8'hff);
    wait (timer1_overflow_flag === 1'b1);
    clk(1);
    chk({timer0_high_byte, timer0_low_byte}, {8'h00, a}, "split");
    chk(16'(timer1_low_byte != b), 16'h1, "t1 baud run");
    timer_mode_register = 8'h20;
    wr_cnt(2, 8'hff);
    wr_cnt(3, 8'hff);
    baud_doubling_bit = 1'b1;
    serial_mode_bit_one = 1'b1;
    tx_chk(8'h5a, 10, 96, {2'b11, 8'h5a, 1'b0});
    receive_enable = 1'b1;
    fork
      u_rem.send({2'b11, 8'ha3, 1'b0}, 10, 96);
      tx_chk(8'h3c, 10, 96, {2'b11, 8'h3c, 1'b0});
    join
    clk(2);
    chk({6'h0, rx_done_flag, received_ninth_bit, serial_buffer_rdata}, 16'h3a3, "rx mode1");
    u_rem.send({2'b11, 8'h66, 1'b0}, 10, 96);
    clk(2);
    chk(16'(serial_buffer_rdata), 16'h66, "overwrite");
    pulse(rx_done_clr);
    receive_enable = 1'b0;
    u_rem.send({2'b11, 8'h11, 1'b0}, 10, 96);
    clk(2);
    chk({7'h0, rx_done_flag, serial_buffer_rdata}, 16'h66, "rx disabled");
    serial_mode_bit_zero = 1'b1;
    serial_mode_bit_one = 1'b0;
    baud_doubling_bit = 1'b0;
    transmit_ninth_bit = 1'b1;
    tx_chk(8'hc5, 11, 32, {2'b11, 8'hc5, 1'b0});
    baud_doubling_bit = 1'b1;
    transmit_ninth_bit = 1'b0;
    tx_chk(8'h3a, 11, 16, {2'b10, 8'h3a, 1'b0});
    receive_enable = 1'b1;
    error_view_select = 1'b1;
    u_rem.send({2'b01, 8'h96, 1'b0}, 11, 16);
    clk(2);
    chk({6'h0, serial_ctrl_bit7, received_ninth_bit, serial_buffer_rdata}, 16'h396, "rx mode2");
    chk(16'(framing_error_flag), 16'h1, "error flag");
    pulse(framing_error_clr);
    clk(1);
    chk(16'(serial_ctrl_bit7), 16'h0, "error cleared");
    error_view_select = 1'b0;
    clk(1);
    chk(16'(serial_ctrl_bit7), 16'h1, "mode bit view");
    serial_mode_bit_one = 1'b1;
    transmit_ninth_bit = 1'b1;
    tx_chk(8'h69, 11, 96, {2'b11, 8'h69, 1'b0});
    receive_enable = 1'b0;
    serial_mode_bit_zero = 1'b0;
    serial_mode_bit_one = 1'b0;
    wr_serial_buffer(8'hb4);
    u_rem.get_shift(sd, per);
    chk({sd, 8'(per)}, 16'hb406, "shift out");
    clk(6);
    receive_enable = 1'b1;
    clk(30);
    chk({7'h0, rx_done_flag, serial_buffer_rdata}, 16'h196, "mode0 rx held");
    pulse(rx_done_clr);
    clk(60);
    chk({7'h0, rx_done_flag, serial_buffer_rdata}, 16'h1ff, "mode0 rx");
    summarize();
  end
endmodule

// ===== verification/utm_remote.sv
// remote serial device model: async frame source and sink, shift-mode sink
`timescale 1ns/100ps
module utm_remote
(
  input  wire logic core_clk,
  input  wire logic tx_line,
  input  wire logic sdo,
  output logic      rxd
);
  initial rxd = 1'b1;

  // each bit held bt clocks, first bit at index 0, line back to idle high
  task automatic send(input logic [10:0] bits, input int nb, input int bt);
    for (int i = 0; i < nb; i++)
    begin
      @(negedge core_clk);
      rxd = bits[i];
      repeat (bt - 1) @(negedge core_clk);
    end
    @(negedge core_clk);
    rxd = 1'b1;
  endtask

  // waits for the start edge, samples every bit at its middle
  task automatic get(output logic [10:0] bits, input int nb, input int bt);
    bits = '1;
    @(negedge tx_line);
    repeat (bt / 2) @(negedge core_clk);
    for (int i = 0; i < nb; i++)
    begin
      bits[i] = tx_line;
      repeat (bt) @(negedge core_clk);
    end
  endtask

  // shift mode: data is steady at the falling shift clock
  task automatic get_shift(output logic [7:0] d, output int per);
    realtime t;
    t = 0.0;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge tx_line);
      d[i] = sdo;
      if (i == 1)
        per = int'(($realtime - t) / 25.0);
      t = $realtime;
    end
  endtask
endmodule
